// >>> primary_timer.sv
// The implementer's own choice: the APB register port.
module primary_timer
  import timer_pkg::*;
(
  input  wire logic     pclk,
  input  wire logic     presetn,
  input  wire apb_req_t apb_req,
  output apb_rsp_t      apb_rsp,
  input  wire logic     soft_reset_req,
  input  wire logic     sleep_mode,
  input  wire logic     ext_clk_pin,
  input  wire logic     osc_input_pin,
  output logic          osc_amp_enable,
  output logic          irq
);

  // Counting modes, decoded from the run, source and sync bits
  typedef enum logic [1:0] {
    MODE_STOPPED    = 2'b00,
    MODE_TIMER      = 2'b01,
    MODE_SYNC_COUNT = 2'b10,
    MODE_ASYNC_CNT  = 2'b11
  } count_mode_t;

  typedef struct packed {
    logic [7:0]          gctl;
    logic [7:0]          flags;
    logic [7:0]          enables;
    logic [TC_WIDTH-1:0] tcon;
    logic [15:0]         cmp;
    logic [3:0]          cmp_mode;
    logic [1:0]          sync_ext;
    logic [1:0]          sync_osc;
    logic                ext_prev;
    logic                osc_prev;
    logic [31:0]         rdata;
  } ctrl_state_t;

  ctrl_state_t s_q;
  ctrl_state_t s_d;
  logic [15:0] count_q;
  logic [15:0] count_d;

  logic [9:0]  idx;
  logic        addr_ok;
  logic        setup_rd;
  logic        acc_wr;
  logic [7:0]  wbyte;
  logic        wr_lo;
  logic        wr_hi;
  logic        cnt_wr;
  logic        flags_wr;
  logic        ext_rise;
  logic        osc_rise;
  logic        src_rise;
  count_mode_t mode;
  logic        async_cnt;
  logic        raw_tick;
  logic        ps_tick;
  logic        trig_en;
  logic        trig_hit;
  logic        ovf_set;
  logic [7:0]  flag_set;
  logic [7:0]  flag_clr;

  // Which indices answer; used for both write decode and error reply
  function automatic logic reg_hit(input logic [9:0] i);
    case (i)
      IDX_GLOBAL_CTL, IDX_FLAGS, IDX_COUNT_LOW, IDX_COUNT_HIGH,
      IDX_TIMER_CTL, IDX_CMP_LOW, IDX_CMP_HIGH, IDX_CMP_CTL,
      IDX_ENABLES: reg_hit = 1'b1;
      default:     reg_hit = 1'b0;
    endcase
  endfunction

  // Read mux; unimplemented bits read as zero
  function automatic logic [7:0] reg_read(input logic [9:0] i,
                                          input ctrl_state_t s,
                                          input logic [15:0] cnt);
    case (i)
      IDX_GLOBAL_CTL: reg_read = s.gctl;
      IDX_FLAGS:      reg_read = s.flags & PF_IMPL;
      IDX_COUNT_LOW:  reg_read = cnt[7:0];
      IDX_COUNT_HIGH: reg_read = cnt[15:8];
      IDX_TIMER_CTL:  reg_read = {2'b00, s.tcon};
      IDX_CMP_LOW:    reg_read = s.cmp[7:0];
      IDX_CMP_HIGH:   reg_read = s.cmp[15:8];
      IDX_CMP_CTL:    reg_read = {4'h0, s.cmp_mode};
      IDX_ENABLES:    reg_read = s.enables & PF_IMPL;
      default:        reg_read = 8'h00;
    endcase
  endfunction

  // Mode decode; the tick source and the trigger gate both depend on it
  function automatic count_mode_t mode_of(input logic [TC_WIDTH-1:0] tc);
    if (!tc[TC_RUN])
    begin
      mode_of = MODE_STOPPED;
    end
    else if (!tc[TC_CLK_SEL])
    begin
      mode_of = MODE_TIMER;
    end
    else if (!tc[TC_NO_SYNC])
    begin
      mode_of = MODE_SYNC_COUNT;
    end
    else
    begin
      mode_of = MODE_ASYNC_CNT;
    end
  endfunction

  // Rising edge of a synchronised pin against its own previous sample
  function automatic logic rose(input logic lvl,
                                input logic prev);
    rose = lvl && !prev;
  endfunction

  // Bus decode: zero wait states, read data latched in the setup cycle
  assign idx      = apb_req.paddr[11:2];
  assign addr_ok  = reg_hit(idx) && (apb_req.paddr[1:0] == 2'b00);
  assign setup_rd = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
  assign acc_wr   = apb_req.psel && apb_req.penable && apb_req.pwrite && addr_ok;
  assign wbyte    = apb_req.pwdata[7:0];
  assign wr_lo    = acc_wr && (idx == IDX_COUNT_LOW);
  assign wr_hi    = acc_wr && (idx == IDX_COUNT_HIGH);
  assign cnt_wr   = wr_lo || wr_hi;
  assign flags_wr = acc_wr && (idx == IDX_FLAGS);

  // Bus answer
  always_comb
  begin
    apb_rsp.prdata  = s_q.rdata;
    apb_rsp.pready  = 1'b1;
    apb_rsp.pslverr = apb_req.psel && apb_req.penable && !addr_ok;
  end

  // External clock source: synchronised pin, rising edge counts.
  // The crystal input replaces the clock pin while the oscillator runs.
  // Each pin keeps its own previous sample, so a source switch makes no false edge.
  assign ext_rise  = rose(s_q.sync_ext[1], s_q.ext_prev);
  assign osc_rise  = rose(s_q.sync_osc[1], s_q.osc_prev);
  assign src_rise  = s_q.tcon[TC_OSC_EN] ? osc_rise : ext_rise;
  assign mode      = mode_of(s_q.tcon);
  assign async_cnt = (mode == MODE_ASYNC_CNT);

  // Only the unsynchronised counter keeps counting in sleep
  always_comb
  begin
    case (mode)
      MODE_TIMER:      raw_tick = !sleep_mode;
      MODE_SYNC_COUNT: raw_tick = src_rise && !sleep_mode;
      MODE_ASYNC_CNT:  raw_tick = src_rise;
      default:         raw_tick = 1'b0;
    endcase
  end

  tick_prescaler #(
    .CNT_W (PS_CNT_W)
  ) u_prescaler (
    .pclk      (pclk),
    .presetn   (presetn),
    .clear     (cnt_wr),
    .tick_in   (raw_tick && s_q.tcon[TC_RUN]),
    .ratio_sel (s_q.tcon[TC_PS_HI:TC_PS_LO]),
    .tick_out  (ps_tick)
  );

  // Trigger disabled in the asynchronous counter mode
  assign trig_en  = (s_q.cmp_mode == CMP_MODE_SPECIAL) && !async_cnt;
  assign trig_hit = ps_tick && trig_en && (count_q == s_q.cmp);

  // Count path: a bus write beats the trigger
  always_comb
  begin
    count_d = count_q;
    ovf_set = 1'b0;
    if (cnt_wr)
    begin
      if (wr_lo)
      begin
        count_d[7:0] = wbyte;
      end
      if (wr_hi)
      begin
        count_d[15:8] = wbyte;
      end
    end
    else if (trig_hit)
    begin
      count_d = 16'h0000;
    end
    else if (ps_tick)
    begin
      count_d = count_q + 16'h0001;
      ovf_set = (count_q == COUNT_ALL_ONES);
    end
  end

  // Flag sources and write-one-to-clear; a set in the same cycle wins
  always_comb
  begin
    flag_set              = 8'h00;
    flag_set[PF_OVERFLOW] = ovf_set;
    flag_set[PF_COMPARE]  = trig_hit;
    flag_clr              = flags_wr ? wbyte : 8'h00;
  end

  // Control state next value
  always_comb
  begin
    s_d          = s_q;
    s_d.sync_ext = {s_q.sync_ext[0], ext_clk_pin};
    s_d.sync_osc = {s_q.sync_osc[0], osc_input_pin};
    s_d.ext_prev = s_q.sync_ext[1];
    s_d.osc_prev = s_q.sync_osc[1];
    s_d.flags    = ((s_q.flags & ~flag_clr) | flag_set) & PF_IMPL;
    if (setup_rd)
    begin
      s_d.rdata = {24'h000000, reg_read(idx, s_q, count_q)};
    end
    if (acc_wr)
    begin
      case (idx)
        IDX_GLOBAL_CTL: s_d.gctl     = wbyte;
        IDX_TIMER_CTL:  s_d.tcon     = wbyte[TC_WIDTH-1:0];
        IDX_CMP_LOW:    s_d.cmp[7:0] = wbyte;
        IDX_CMP_HIGH:   s_d.cmp[15:8] = wbyte;
        IDX_CMP_CTL:    s_d.cmp_mode = wbyte[3:0];
        IDX_ENABLES:    s_d.enables  = wbyte & PF_IMPL;
        default:        s_d.gctl     = s_d.gctl;
      endcase
    end
    // Soft reset clears interrupt state and compare mode but keeps timer control
    if (soft_reset_req)
    begin
      s_d.gctl     = GLOBAL_CTL_RST;
      s_d.flags    = FLAGS_RST;
      s_d.enables  = ENABLES_RST;
      s_d.cmp_mode = CMP_MODE_RST;
    end
  end

  // Power-on reset clears control, which stops the timer at 1:1
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q          <= '0;
      s_q.gctl     <= GLOBAL_CTL_RST;
      s_q.flags    <= FLAGS_RST;
      s_q.enables  <= ENABLES_RST;
      s_q.tcon     <= TIMER_CTL_RST;
      s_q.cmp      <= CMP_RST;
      s_q.cmp_mode <= CMP_MODE_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Count holds its value across every reset, so it has none
  always_ff @(posedge pclk)
  begin
    count_q <= count_d;
  end

  // Crystal amplifier enable ignores sleep on purpose
  assign osc_amp_enable = s_q.tcon[TC_OSC_EN];

  // Level interrupt through peripheral and global gates
  assign irq = s_q.gctl[GC_GLOBAL_GATE] && s_q.gctl[GC_PERIPH_GATE]
               && |(s_q.flags & s_q.enables);

endmodule // primary_timer

// >>> tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import timer_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  apb_req_t    req = '0;
  apb_rsp_t    rsp;
  logic        srst = 1'b0;
  logic        slp = 1'b0;
  logic        ext, osc, amp, irq, err;
  logic [31:0] rd;
  logic [7:0]  cnt;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          cyc = 0;
  always #2 pclk = ~pclk;
  primary_timer dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .soft_reset_req(srst),
    .sleep_mode(slp), .ext_clk_pin(ext), .osc_input_pin(osc), .osc_amp_enable(amp), .irq(irq));
  xtal_model xtal (.amp_en(amp), .osc(osc), .ext_clk(ext));
  task results;
    $display("Mismatches %0d of %0d compares", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; request held until pready is seen at an edge
  task xfer(input logic [11:0] a, input logic w, input logic [7:0] d);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, d}};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (rsp.pready !== 1'b1);
    rd  = rsp.prdata;
    err = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task wr(input logic [9:0] i, input logic [7:0] d);
    xfer({i, 2'b00}, 1'b1, d);
  endtask
  task rdc(input logic [9:0] i, input logic [7:0] e);
    xfer({i, 2'b00}, 1'b0, 8'h00);
    chk(rd, {24'h0, e});
  endtask
  // Hang guard
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      results;
    end
  end
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc(IDX_TIMER_CTL, 8'h00);
    rdc(IDX_FLAGS, 8'h00);
    rdc(IDX_ENABLES, 8'h00);
    wr(IDX_TIMER_CTL, 8'hF8);
    rdc(IDX_TIMER_CTL, 8'h38);
    chk({31'h0, amp}, 32'h1);
    repeat (200) @(posedge pclk);
    // Asynchronous crystal counting must carry on through sleep
    wr(IDX_COUNT_LOW, 8'h00);
    wr(IDX_COUNT_HIGH, 8'h00);
    slp <= 1'b1;
    wr(IDX_TIMER_CTL, 8'h0F);
    repeat (150) @(posedge pclk);
    chk({31'h0, amp}, 32'h1);
    wr(IDX_TIMER_CTL, 8'h08);
    slp <= 1'b0;
    xfer({IDX_COUNT_LOW, 2'b00}, 1'b0, 8'h00);
    cnt = rd[7:0];
    chk({31'h0, cnt != 8'h00}, 32'h1);
    srst <= 1'b1;
    @(posedge pclk);
    srst <= 1'b0;
    rdc(IDX_TIMER_CTL, 8'h08);
    rdc(IDX_COUNT_LOW, cnt);
    // Rollover sets the overflow flag and the gated interrupt
    wr(IDX_COUNT_LOW, 8'hF0);
    wr(IDX_COUNT_HIGH, 8'hFF);
    wr(IDX_TIMER_CTL, 8'h01);
    repeat (30) @(posedge pclk);
    wr(IDX_TIMER_CTL, 8'h00);
    rdc(IDX_COUNT_HIGH, 8'h00);
    rdc(IDX_FLAGS, 8'h01);
    wr(IDX_ENABLES, 8'h01);
    wr(IDX_GLOBAL_CTL, 8'hC0);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h1);
    wr(IDX_GLOBAL_CTL, 8'h40);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(IDX_GLOBAL_CTL, 8'h00);
    wr(IDX_FLAGS, 8'h01);
    rdc(IDX_FLAGS, 8'h00);
    // Trigger mode: compare pair is the period, flag bit 0 untouched
    wr(IDX_CMP_LOW, 8'h05);
    wr(IDX_CMP_HIGH, 8'h00);
    wr(IDX_CMP_CTL, 8'h0B);
    wr(IDX_COUNT_LOW, 8'h00);
    wr(IDX_TIMER_CTL, 8'h01);
    repeat (50) @(posedge pclk);
    wr(IDX_TIMER_CTL, 8'h00);
    rdc(IDX_COUNT_HIGH, 8'h00);
    xfer({IDX_COUNT_LOW, 2'b00}, 1'b0, 8'h00);
    chk({31'h0, rd[7:0] <= 8'h05}, 32'h1);
    rdc(IDX_FLAGS, 8'h04);
    // Synchronised pin counting keeps the trigger active; about 16 pin edges pass
    wr(IDX_COUNT_LOW, 8'h00);
    wr(IDX_TIMER_CTL, 8'h03);
    repeat (300) @(posedge pclk);
    wr(IDX_TIMER_CTL, 8'h00);
    xfer({IDX_COUNT_LOW, 2'b00}, 1'b0, 8'h00);
    chk({31'h0, rd[7:0] <= 8'h05}, 32'h1);
    rdc(IDX_COUNT_HIGH, 8'h00);
    // Count writes restart a 1:8 prescaler, so it never reaches a tick
    wr(IDX_CMP_CTL, 8'h00);
    wr(IDX_TIMER_CTL, 8'h31);
    repeat (10) wr(IDX_COUNT_LOW, 8'h00);
    wr(IDX_TIMER_CTL, 8'h00);
    rdc(IDX_COUNT_LOW, 8'h00);
    // A 1:4 prescale over 43 running cycles passes ten ticks
    wr(IDX_COUNT_LOW, 8'h00);
    wr(IDX_TIMER_CTL, 8'h21);
    repeat (40) @(posedge pclk);
    wr(IDX_TIMER_CTL, 8'h00);
    rdc(IDX_COUNT_LOW, 8'h0A);
    // Refused places
    xfer(12'h0FC, 1'b0, 8'h00);
    chk({31'h0, err}, 32'h1);
    xfer(12'h041, 1'b1, 8'hFF);
    rdc(IDX_TIMER_CTL, 8'h00);
    results;
  end
endmodule // tb_top

// >>> tick_prescaler.sv
module tick_prescaler
  import timer_pkg::*;
#(
  parameter int unsigned CNT_W = PS_CNT_W
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clear,
  input  wire logic       tick_in,
  input  wire logic [1:0] ratio_sel,
  output logic            tick_out
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } ps_state_t;

  ps_state_t s_q;
  ps_state_t s_d;
  logic [CNT_W-1:0] need_ones;

  // Ratio 1:2^sel passes a tick once the low sel bits are all ones
  always_comb
  begin
    s_d       = s_q;
    need_ones = CNT_W'((1 << ratio_sel) - 1);
    tick_out  = tick_in && ((s_q.cnt & need_ones) == need_ones);
    if (clear)
    begin
      s_d.cnt = '0;
    end
    else if (tick_in)
    begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  // Counter state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

endmodule // tick_prescaler

// >>> timer_chk.sv
module timer_chk
  import timer_pkg::*;
(
  input wire logic     pclk,
  input wire logic     presetn,
  input wire apb_req_t apb_req,
  input wire apb_rsp_t apb_rsp,
  input wire logic     soft_reset_req,
  input wire logic     sleep_mode,
  input wire logic     osc_amp_enable,
  input wire logic     irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic ctl_wr;
  // Access phase, and a completed control write
  assign acc    = apb_req.psel && apb_req.penable;
  assign ctl_wr = acc && apb_req.pwrite && apb_req.paddr == {IDX_TIMER_CTL, 2'b00};
  sequence s_wr(logic [9:0] idx, logic [7:0] d);
    acc && apb_req.pwrite && apb_req.paddr == {idx, 2'b00} && apb_req.pwdata[7:0] == d;
  endsequence
  sequence s_ctl_rd;
    acc && !apb_req.pwrite && apb_req.paddr == {IDX_TIMER_CTL, 2'b00};
  endsequence
  a_ready_always: assert property (apb_rsp.pready) else $error("pready low");
  a_osc_follow: assert property (ctl_wr |=> osc_amp_enable == $past(apb_req.pwdata[TC_OSC_EN]))
    else $error("amp enable not following bit 3");
  a_osc_sleep: assert property (sleep_mode && !ctl_wr |=> $stable(osc_amp_enable))
    else $error("amp enable moved in sleep");
  a_osc_soft: assert property (soft_reset_req && !ctl_wr |=> $stable(osc_amp_enable))
    else $error("soft reset touched control");
  a_osc_por: assert property ($rose(presetn) |-> !osc_amp_enable)
    else $error("amp enable high after power-on");
  a_ctl_unimpl: assert property (s_ctl_rd |-> apb_rsp.prdata[31:6] == 26'h0)
    else $error("control upper bits not zero");
  a_misalign_err: assert property (acc && apb_req.paddr[1:0] != 2'b00 |-> apb_rsp.pslverr)
    else $error("misaligned access not refused");
  a_err_idle: assert property (!acc |-> !apb_rsp.pslverr) else $error("pslverr outside access");
  a_irq_gate: assert property (s_wr(IDX_GLOBAL_CTL, 8'h00) |=> !irq [*2])
    else $error("irq with global gate off");
  a_irq_en_off: assert property (s_wr(IDX_ENABLES, 8'h00) |=> !irq)
    else $error("irq with enables off");
endmodule // timer_chk

bind primary_timer timer_chk u_chk (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .soft_reset_req(soft_reset_req), .sleep_mode(sleep_mode), .osc_amp_enable(osc_amp_enable), .irq(irq));

// >>> timer_pkg.sv
package timer_pkg;

  // APB transfer carriers
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_GLOBAL_CTL   = 10'h00B;
  localparam logic [9:0] IDX_FLAGS        = 10'h00C;
  localparam logic [9:0] IDX_COUNT_LOW    = 10'h00E;
  localparam logic [9:0] IDX_COUNT_HIGH   = 10'h00F;
  localparam logic [9:0] IDX_TIMER_CTL    = 10'h010;
  localparam logic [9:0] IDX_CMP_LOW      = 10'h015;
  localparam logic [9:0] IDX_CMP_HIGH     = 10'h016;
  localparam logic [9:0] IDX_CMP_CTL      = 10'h017;
  localparam logic [9:0] IDX_ENABLES      = 10'h08C;

  // Timer control fields
  localparam int unsigned TC_RUN     = 0;
  localparam int unsigned TC_CLK_SEL = 1;
  localparam int unsigned TC_NO_SYNC = 2;
  localparam int unsigned TC_OSC_EN  = 3;
  localparam int unsigned TC_PS_LO   = 4;
  localparam int unsigned TC_PS_HI   = 5;
  localparam int unsigned TC_WIDTH   = 6;

  // Global interrupt control fields
  localparam int unsigned GC_PERIPH_GATE = 6;
  localparam int unsigned GC_GLOBAL_GATE = 7;

  // Peripheral flag and enable fields
  localparam int unsigned PF_OVERFLOW = 0;
  localparam int unsigned PF_COMPARE  = 2;
  localparam logic [7:0]  PF_IMPL     = 8'h05;

  // Reset values
  localparam logic [7:0]  GLOBAL_CTL_RST = 8'h00;
  localparam logic [7:0]  FLAGS_RST      = 8'h00;
  localparam logic [7:0]  ENABLES_RST    = 8'h00;
  localparam logic [5:0]  TIMER_CTL_RST  = 6'h00;
  localparam logic [15:0] CMP_RST        = 16'h0000;
  localparam logic [3:0]  CMP_MODE_RST   = 4'h0;

  // Compare mode that produces the special event trigger
  localparam logic [3:0]  CMP_MODE_SPECIAL = 4'hB;
  localparam logic [15:0] COUNT_ALL_ONES   = 16'hFFFF;

  // Prescaler counter width (largest ratio 1:8)
  localparam int unsigned PS_CNT_W = 3;

endpackage : timer_pkg

// >>> xtal_model.sv
module xtal_model (
  input  wire logic amp_en,
  output logic      osc,
  output logic      ext_clk
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    osc     = 1'b0;
    ext_clk = 1'b0;
  end
  // Crystal swings only while amplified; it knows nothing of sleep, so it keeps going
  always #30 osc = amp_en ? ~osc : 1'b0;
  // Free-running pin clock, unrelated in phase to pclk
  always #37 ext_clk = ~ext_clk;
endmodule // xtal_model
